//--- rtl/tcc_pkg.sv
// Constants and types shared by the 16-bit capture/compare timer files
// Behaviour
// - Clock select: event pin, fine, coarse, none
// - Reset selects the event pin clock
// - Fine and coarse taps from shared prescaler
// - Run bit starts, stops, holds counter cleared
// - Clear bit: clear only at second match
// - Each compare match raises its own interrupt
// - Capture select 00 disables; reset default
// - Select 01: A rise first, B rise second
// - Select 10: A rise/fall; interrupt on fall
// - Select 11: eight-bit toggle rise/fall captures
// - Writing 0 captures first; bit reads 1
// - Four enabled sources invert the toggle flop
// - Software inverts, clears or sets toggle flop
// - Pin driven when port bit 3, mode 11
// - Event clock counts each event rising edge
// - Interval: second match clears and interrupts
// - Pulse: both matches toggle, second clears
package tcc_pkg;

	// ************************************************************
	// Register byte addresses
	// ************************************************************
	localparam logic [15:0] TCC_ADDR_CAPTURE_FIRST_VALUE_LO = 16'hffdc;
	localparam logic [15:0] TCC_ADDR_CAPTURE_FIRST_VALUE_HI = 16'hffdd;
	localparam logic [15:0] TCC_ADDR_CAPTURE_SECOND_VALUE_LO = 16'hffde;
	localparam logic [15:0] TCC_ADDR_CAPTURE_SECOND_VALUE_HI = 16'hffdf;
	localparam logic [15:0] TCC_ADDR_CMP1_LO = 16'hffe0;
	localparam logic [15:0] TCC_ADDR_CMP1_HI = 16'hffe1;
	localparam logic [15:0] TCC_ADDR_CMP2_LO = 16'hffe2;
	localparam logic [15:0] TCC_ADDR_CMP2_HI = 16'hffe3;
	localparam logic [15:0] TCC_ADDR_MODE = 16'hffe4;
	localparam logic [15:0] TCC_ADDR_TOGGLE = 16'hffe5;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int TCC_MODE_CLK_LSB = 0;
	localparam int TCC_MODE_CLE_BIT = 2;
	localparam int TCC_MODE_CAPTURE_EDGE_SELECT_LSB = 3;
	localparam int TCC_MODE_SOFTWARE_CAPTURE_TRIGGER_BIT = 5;
	localparam int TCC_TGL_SW_LSB = 0;
	localparam int TCC_TGL_EN_LSB = 2;
	localparam int TCC_P8_TOGGLE_BIT = 3;
	localparam int TCC_MOTOR_MODE_LSB = 4;

	// ************************************************************
	// Values
	// ************************************************************
	localparam logic [1:0] TCC_MOTOR_MODE_TOGGLE = 2'h3;
	localparam logic [15:0] TCC_ZERO16 = 16'h0000;
	localparam logic [15:0] TCC_ONE16 = 16'h0001;
	localparam logic [7:0] TCC_ZERO8 = 8'h00;
	localparam logic [7:0] TCC_READ_UNMAPPED = 8'h00;
	localparam logic [1:0] TCC_READ_ONES2 = 2'h3;
	localparam logic [3:0] TCC_TOGGLE_EN_RESET = 4'h0;

	typedef enum logic [1:0] {
		TCC_CLK_EVENT = 2'h0,
		TCC_CLK_FINE = 2'h1,
		TCC_CLK_COARSE = 2'h2,
		TCC_CLK_NONE = 2'h3
	} tcc_clk_sel_t;

	typedef enum logic [1:0] {
		TCC_CAP_OFF = 2'h0,
		TCC_CAP_A_B_RISE = 2'h1,
		TCC_CAP_A_BOTH = 2'h2,
		TCC_CAP_TOGGLE = 2'h3
	} tcc_cap_sel_t;

	typedef enum logic [1:0] {
		TCC_SW_CLEAR = 2'h0,
		TCC_SW_SET = 2'h1,
		TCC_SW_INVERT = 2'h2,
		TCC_SW_KEEP = 2'h3
	} tcc_sw_tgl_t;

endpackage

//--- rtl/tcc_cmp_if.sv
// Interface between the counter and one comparator
`timescale 1ns/1ps
interface tcc_cmp_if;
	logic [15:0] count_next;
	logic count_step;
	logic [15:0] limit;
	logic match;
	modport counter (output count_next, output count_step, output limit, input match);
	modport compare (input count_next, input count_step, input limit, output match);
endinterface

//--- rtl/tcc_pin_sync.sv
// Three-flop synchroniser with rise and fall pulses for one pin
`timescale 1ns/1ps
module tcc_pin_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic pin_in,
	output logic rise,
	output logic fall
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic rise;
		logic fall;
	} tcc_sync_state_t;

	tcc_sync_state_t st;
	tcc_sync_state_t next_st;

	// A change counts once the second and third stages agree
	always_comb begin
		next_st = st;
		next_st.s1 = pin_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.rise = 1'b0;
		next_st.fall = 1'b0;
		if (st.s2 == st.s3 && st.s3 != st.level) begin
			next_st.level = st.s3;
			next_st.rise = st.s3;
			next_st.fall = !st.s3;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rise = st.rise;
	assign fall = st.fall;
endmodule

//--- rtl/tcc_compare.sv
// One 16-bit comparator with a single-cycle match pulse
`timescale 1ns/1ps
module tcc_compare (
	input wire logic clk,
	input wire logic rst,
	tcc_cmp_if.compare port_cmp
);
	typedef struct packed {
		logic match;
	} tcc_cmp_state_t;

	tcc_cmp_state_t st;
	tcc_cmp_state_t next_st;

	// Look at the value the counter is about to take, so the pulse lands
	// in the first cycle of equality and not again while the count rests
	always_comb begin
		next_st = st;
		next_st.match = port_cmp.count_step && (port_cmp.count_next == port_cmp.limit);
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign port_cmp.match = st.match;
endmodule

//--- rtl/tcc_timer16.sv
// 16-bit timer/event counter with two compares, two captures, toggle output
`timescale 1ns/1ps
module tcc_timer16 import tcc_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic counter_run_bit,
	input wire logic fine_prescale_clock,
	input wire logic coarse_prescale_clock,
	input wire logic event_input_a,
	input wire logic event_input_b,
	input wire logic eight_bit_timer_toggle,
	input wire logic [7:0] port_eight_control,
	input wire logic [7:0] motor_port_mode,
	output logic first_match_irq,
	output logic second_match_irq,
	output logic external_irq_a,
	output logic output_toggle_ff,
	output logic toggle_output_pin,
	output logic toggle_output_oe
);
	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [15:0] count;
		logic [15:0] cmp_first;
		logic [15:0] cmp_second;
		logic [7:0] cmp_first_lo;
		logic [7:0] cmp_second_lo;
		logic [15:0] cap_first;
		logic [15:0] cap_second;
		logic [7:0] cap_first_hi;
		logic [7:0] cap_second_hi;
		tcc_clk_sel_t clk_sel;
		logic clear_en;
		tcc_cap_sel_t cap_sel;
		logic [3:0] toggle_en;
		logic toggle_ff;
		logic eight_bit_timer_toggle_prev;
		logic [7:0] rdata;
		logic irq_first;
		logic irq_second;
		logic irq_a;
		logic pin;
		logic pin_oe;
	} tcc_state_t;

	tcc_state_t st;
	tcc_state_t next_st;

	logic a_rise;
	logic a_fall;
	logic b_rise;
	logic tick;
	logic step;
	logic clear_hit;
	logic [15:0] count_next;
	logic m_first;
	logic m_second;
	logic sw_cap;
	logic t1_rise;
	logic t1_fall;
	logic capture_first_value_evt;
	logic capture_second_value_evt;
	logic hw_toggle;
	logic toggle_wr;
	tcc_sw_tgl_t sw_tgl;

	// ************************************************************
	// Pin synchronisers and comparators
	// ************************************************************
	tcc_pin_sync u_sync_a (
		.clk(clk),
		.rst(rst),
		.pin_in(event_input_a),
		.rise(a_rise),
		.fall(a_fall)
	);

	tcc_pin_sync u_sync_b (
		.clk(clk),
		.rst(rst),
		.pin_in(event_input_b),
		.rise(b_rise),
		.fall()
	);

	tcc_cmp_if cmp_first_bus ();
	tcc_cmp_if cmp_second_bus ();

	tcc_compare u_cmp_first (
		.clk(clk),
		.rst(rst),
		.port_cmp(cmp_first_bus.compare)
	);

	tcc_compare u_cmp_second (
		.clk(clk),
		.rst(rst),
		.port_cmp(cmp_second_bus.compare)
	);

	// Both comparators see the same upcoming count
	assign cmp_first_bus.count_next = count_next;
	assign cmp_first_bus.count_step = step;
	assign cmp_first_bus.limit = st.cmp_first;
	assign cmp_second_bus.count_next = count_next;
	assign cmp_second_bus.count_step = step;
	assign cmp_second_bus.limit = st.cmp_second;
	assign m_first = cmp_first_bus.match;
	assign m_second = cmp_second_bus.match;

	// ************************************************************
	// Counter
	// ************************************************************
	// Taps are one-cycle enables from the shared prescaler; code 11 never ticks
	assign tick = (st.clk_sel == TCC_CLK_EVENT && a_rise)
		|| (st.clk_sel == TCC_CLK_FINE && fine_prescale_clock)
		|| (st.clk_sel == TCC_CLK_COARSE && coarse_prescale_clock);
	assign step = counter_run_bit && tick;
	assign clear_hit = st.clear_en && (st.count == st.cmp_second);
	// Stopped means held at zero; plain add wraps at all ones
	assign count_next = !counter_run_bit ? TCC_ZERO16
		: !step ? st.count
		: clear_hit ? TCC_ZERO16
		: st.count + TCC_ONE16;

	// ************************************************************
	// Capture and toggle sources
	// ************************************************************
	assign sw_cap = bus_wr && bus_addr == TCC_ADDR_MODE && !bus_wdata[TCC_MODE_SOFTWARE_CAPTURE_TRIGGER_BIT];
	// The eight-bit timer toggle is on this clock, so no synchroniser
	assign t1_rise = eight_bit_timer_toggle && !st.eight_bit_timer_toggle_prev;
	assign t1_fall = !eight_bit_timer_toggle && st.eight_bit_timer_toggle_prev;
	assign capture_first_value_evt = sw_cap
		|| (st.cap_sel == TCC_CAP_A_B_RISE && a_rise)
		|| (st.cap_sel == TCC_CAP_A_BOTH && a_rise)
		|| (st.cap_sel == TCC_CAP_TOGGLE && t1_rise);
	assign capture_second_value_evt = (st.cap_sel == TCC_CAP_A_B_RISE && b_rise)
		|| (st.cap_sel == TCC_CAP_A_BOTH && a_fall)
		|| (st.cap_sel == TCC_CAP_TOGGLE && t1_fall);
	// Enable bits ordered {second capture, first capture, second match, first match}
	assign hw_toggle = |({capture_second_value_evt, capture_first_value_evt, m_second, m_first} & st.toggle_en);
	assign toggle_wr = bus_wr && bus_addr == TCC_ADDR_TOGGLE;
	assign sw_tgl = tcc_sw_tgl_t'(bus_wdata[TCC_TGL_SW_LSB +: 2]);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_st = st;
		next_st.count = count_next;
		next_st.eight_bit_timer_toggle_prev = eight_bit_timer_toggle;
		if (capture_first_value_evt) begin
			next_st.cap_first = st.count;
		end
		if (capture_second_value_evt) begin
			next_st.cap_second = st.count;
		end
		// Software action wins over a hardware inversion in the same cycle
		if (toggle_wr && sw_tgl != TCC_SW_KEEP) begin
			unique case (sw_tgl)
				TCC_SW_CLEAR: next_st.toggle_ff = 1'b0;
				TCC_SW_SET: next_st.toggle_ff = 1'b1;
				TCC_SW_INVERT: next_st.toggle_ff = !st.toggle_ff;
				TCC_SW_KEEP: next_st.toggle_ff = st.toggle_ff;
			endcase
		end else if (hw_toggle) begin
			next_st.toggle_ff = !st.toggle_ff;
		end
		// Interrupt pulses; INT line follows the falling edge only in mode 10
		next_st.irq_first = m_first;
		next_st.irq_second = m_second;
		next_st.irq_a = (st.cap_sel == TCC_CAP_A_BOTH) ? a_fall : a_rise;
		next_st.pin = st.toggle_ff;
		next_st.pin_oe = port_eight_control[TCC_P8_TOGGLE_BIT]
			&& motor_port_mode[TCC_MOTOR_MODE_LSB +: 2] == TCC_MOTOR_MODE_TOGGLE;
		// Register writes; compare takes both bytes at the high-byte write
		if (bus_wr) begin
			unique case (bus_addr)
				TCC_ADDR_CMP1_LO: next_st.cmp_first_lo = bus_wdata;
				TCC_ADDR_CMP1_HI: next_st.cmp_first = {bus_wdata, st.cmp_first_lo};
				TCC_ADDR_CMP2_LO: next_st.cmp_second_lo = bus_wdata;
				TCC_ADDR_CMP2_HI: next_st.cmp_second = {bus_wdata, st.cmp_second_lo};
				TCC_ADDR_MODE: begin
					next_st.clk_sel = tcc_clk_sel_t'(bus_wdata[TCC_MODE_CLK_LSB +: 2]);
					next_st.clear_en = bus_wdata[TCC_MODE_CLE_BIT];
					next_st.cap_sel = tcc_cap_sel_t'(bus_wdata[TCC_MODE_CAPTURE_EDGE_SELECT_LSB +: 2]);
				end
				TCC_ADDR_TOGGLE: next_st.toggle_en = bus_wdata[TCC_TGL_EN_LSB +: 4];
				default: next_st.toggle_en = st.toggle_en;
			endcase
		end
		// Reads; a low-byte capture read freezes the high byte for the next read
		if (bus_rd) begin
			unique case (bus_addr)
				TCC_ADDR_CAPTURE_FIRST_VALUE_LO: begin
					next_st.rdata = st.cap_first[7:0];
					next_st.cap_first_hi = st.cap_first[15:8];
				end
				TCC_ADDR_CAPTURE_FIRST_VALUE_HI: next_st.rdata = st.cap_first_hi;
				TCC_ADDR_CAPTURE_SECOND_VALUE_LO: begin
					next_st.rdata = st.cap_second[7:0];
					next_st.cap_second_hi = st.cap_second[15:8];
				end
				TCC_ADDR_CAPTURE_SECOND_VALUE_HI: next_st.rdata = st.cap_second_hi;
				TCC_ADDR_MODE: next_st.rdata = {TCC_READ_ONES2, 1'b1, st.cap_sel,
					st.clear_en, st.clk_sel};
				TCC_ADDR_TOGGLE: next_st.rdata = {TCC_READ_ONES2, st.toggle_en,
					TCC_READ_ONES2};
				default: next_st.rdata = TCC_READ_UNMAPPED;
			endcase
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
			st.clk_sel <= TCC_CLK_EVENT;
			st.cap_sel <= TCC_CAP_OFF;
			st.toggle_en <= TCC_TOGGLE_EN_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign bus_rdata = st.rdata;
	assign first_match_irq = st.irq_first;
	assign second_match_irq = st.irq_second;
	assign external_irq_a = st.irq_a;
	assign output_toggle_ff = st.toggle_ff;
	assign toggle_output_pin = st.pin;
	assign toggle_output_oe = st.pin_oe;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_run_hold;
		!counter_run_bit |=> st.count == TCC_ZERO16;
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("stopped counter not zero");

	property p_fine_count;
		counter_run_bit && st.clk_sel == TCC_CLK_FINE && fine_prescale_clock && !clear_hit
			|=> st.count == $past(st.count) + TCC_ONE16;
	endproperty
	a_fine_count: assert property (p_fine_count) else $error("fine tap did not count");

	property p_event_count;
		counter_run_bit && st.clk_sel == TCC_CLK_EVENT && a_rise && !clear_hit
			|=> st.count == $past(st.count) + TCC_ONE16;
	endproperty
	a_event_count: assert property (p_event_count) else $error("event not counted");

	property p_none_hold;
		counter_run_bit && st.clk_sel == TCC_CLK_NONE |=> $stable(st.count);
	endproperty
	a_none_hold: assert property (p_none_hold) else $error("unused clock code counted");

	property p_clear;
		step && st.clear_en && st.count == st.cmp_second |=> st.count == TCC_ZERO16;
	endproperty
	a_clear: assert property (p_clear) else $error("no clear at second match");

	property p_wrap;
		step && !clear_hit && st.count == 16'hffff |=> st.count == TCC_ZERO16;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap");

	property p_match_irq;
		step && count_next == st.cmp_first && !$past(rst) |=> ##1 first_match_irq;
	endproperty
	a_match_irq: assert property (p_match_irq) else $error("first match irq missing");

	// A second match pulse needs a tick onto the compare value two cycles earlier
	property p_match_once;
		second_match_irq |-> $past(step, 2) && $past(count_next, 2) == $past(st.cmp_second, 2);
	endproperty
	a_match_once: assert property (p_match_once) else $error("bad second match");

	property p_sw_capture;
		sw_cap |=> st.cap_first == $past(st.count);
	endproperty
	a_sw_capture: assert property (p_sw_capture) else $error("software capture lost");

	property p_fall_capture;
		st.cap_sel == TCC_CAP_A_BOTH && a_fall |=> st.cap_second == $past(st.count)
			&& external_irq_a;
	endproperty
	a_fall_capture: assert property (p_fall_capture) else $error("fall capture wrong");

	property p_capture_off;
		st.cap_sel == TCC_CAP_OFF && !sw_cap |=> $stable(st.cap_first) && $stable(st.cap_second);
	endproperty
	a_capture_off: assert property (p_capture_off) else $error("capture while off");

	property p_hw_toggle;
		hw_toggle && !toggle_wr |=> output_toggle_ff != $past(output_toggle_ff);
	endproperty
	a_hw_toggle: assert property (p_hw_toggle) else $error("toggle flop not inverted");

	property p_pin;
		port_eight_control[TCC_P8_TOGGLE_BIT]
			&& motor_port_mode[TCC_MOTOR_MODE_LSB +: 2] == TCC_MOTOR_MODE_TOGGLE
			|=> toggle_output_oe && toggle_output_pin == $past(output_toggle_ff);
	endproperty
	a_pin: assert property (p_pin) else $error("pin not driven by toggle flop");

	property p_second_irq;
		step && count_next == st.cmp_second |=> ##1 second_match_irq;
	endproperty
	a_second_irq: assert property (p_second_irq) else $error("second match irq missing");

	property p_b_capture;
		st.cap_sel == TCC_CAP_A_B_RISE && b_rise |=> st.cap_second == $past(st.count);
	endproperty
	a_b_capture: assert property (p_b_capture) else $error("pin b capture wrong");

	property p_toggle_capture;
		st.cap_sel == TCC_CAP_TOGGLE && t1_rise |=> st.cap_first == $past(st.count);
	endproperty
	a_toggle_capture: assert property (p_toggle_capture) else $error("toggle capture wrong");

	property p_sw_set;
		toggle_wr && sw_tgl == TCC_SW_SET |=> output_toggle_ff;
	endproperty
	a_sw_set: assert property (p_sw_set) else $error("software set lost");

	property p_sw_clear;
		toggle_wr && sw_tgl == TCC_SW_CLEAR |=> !output_toggle_ff;
	endproperty
	a_sw_clear: assert property (p_sw_clear) else $error("software clear lost");

	// First cycle out of reset still shows the reset selections
	property p_reset_select;
		$past(rst) |-> st.clk_sel == TCC_CLK_EVENT && st.cap_sel == TCC_CAP_OFF;
	endproperty
	a_reset_select: assert property (p_reset_select) else $error("reset select wrong");

	c_interval: cover property (step && clear_hit ##1 st.count == TCC_ZERO16);
	c_pulse: cover property (m_first && st.toggle_en[0] ##[1:1000] m_second && st.toggle_en[1]);
	c_width: cover property (st.cap_sel == TCC_CAP_A_BOTH && a_rise ##[1:1000] a_fall);
	c_toggle_cap: cover property (st.cap_sel == TCC_CAP_TOGGLE && t1_fall);
endmodule

//--- rtl/tcc_unused_guard.sv
// No logic here; the timer is built from the other design files

//--- testbench/tcc_event_src.sv
// Model of the prescaler taps, event pins and eight-bit toggle around the timer
`timescale 1ns/1ps
module tcc_event_src (
	input wire logic clk,
	input wire logic fine_req,
	input wire logic coarse_req,
	input wire logic [2:0] pin_req,
	output logic fine_prescale_clock,
	output logic coarse_prescale_clock,
	output logic event_input_a,
	output logic event_input_b,
	output logic eight_bit_timer_toggle
);
	// ************************************************************
	// Sources
	// ************************************************************
	// Taps are one-cycle enables from the shared prescaler
	always_ff @(posedge clk) begin
		fine_prescale_clock <= fine_req;
		coarse_prescale_clock <= coarse_req;
	end

	// Pins move slowly; each level is held long enough to clear the synchroniser
	always_ff @(posedge clk) begin
		event_input_a <= pin_req[0];
		event_input_b <= pin_req[1];
		eight_bit_timer_toggle <= pin_req[2];
	end
endmodule

//--- testbench/tcc_timer16_test.sv
// Self-checking bench for the 16-bit capture/compare timer
`timescale 1ns/1ps
module tcc_timer16_test import tcc_pkg::*; ;
	// ************************************************************
	// Signals
	// ************************************************************
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic run = 1'b0;
	logic fine_req = 1'b0;
	logic coarse_req = 1'b0;
	logic [2:0] pin_req = 3'h0;
	logic [15:0] bus_addr = 16'h0000;
	logic [7:0] bus_wdata = 8'h00;
	logic [7:0] p8 = 8'h00;
	logic [7:0] smm = 8'h00;
	logic [7:0] bus_rdata;
	logic fine, coarse, ea, eb, et, m1, m2, xa, tff, tpin, toe;
	logic tff_q = 1'b0;
	int num_errors = 0;
	int n_tests = 0;
	int n_m1 = 0;
	int n_m2 = 0;
	int n_xa = 0;
	int n_flip = 0;

	always #4 clk = ~clk;

	tcc_event_src src (.clk(clk), .fine_req(fine_req), .coarse_req(coarse_req),
		.pin_req(pin_req), .fine_prescale_clock(fine), .coarse_prescale_clock(coarse),
		.event_input_a(ea), .event_input_b(eb), .eight_bit_timer_toggle(et));

	tcc_timer16 uut (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .counter_run_bit(run),
		.fine_prescale_clock(fine), .coarse_prescale_clock(coarse), .event_input_a(ea),
		.event_input_b(eb), .eight_bit_timer_toggle(et), .port_eight_control(p8),
		.motor_port_mode(smm), .first_match_irq(m1), .second_match_irq(m2),
		.external_irq_a(xa), .output_toggle_ff(tff), .toggle_output_pin(tpin),
		.toggle_output_oe(toe));

	// Pulse and flip tallies; a pulse two cycles wide would count twice
	always @(posedge clk) begin
		if (m1 === 1'b1) n_m1++;
		if (m2 === 1'b1) n_m2++;
		if (xa === 1'b1) n_xa++;
		if (tff !== tff_q) n_flip++;
		tff_q <= tff;
	end

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// A gap cycle between writes keeps the strobe from being driven twice at once
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1 d = bus_rdata;
	endtask

	task automatic wr16(input logic [15:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 16'h0001, v[15:8]);
	endtask

	task automatic rd16(input logic [15:0] a, output logic [15:0] v);
		logic [7:0] lo, hi;
		rd(a, lo);
		rd(a + 16'h0001, hi);
		v = {hi, lo};
	endtask

	task automatic mode(input logic [1:0] cap, input logic cle, input logic [1:0] cs,
		input logic trig);
		wr(TCC_ADDR_MODE, {2'b00, trig, cap, cle, cs});
	endtask

	task automatic tick(input logic coarse_tap, input int k);
		for (int i = 0; i < k; i++) begin
			@(posedge clk);
			if (coarse_tap) coarse_req <= 1'b1;
			else fine_req <= 1'b1;
			@(posedge clk);
			coarse_req <= 1'b0;
			fine_req <= 1'b0;
		end
		repeat (4) @(posedge clk);
	endtask

	task automatic pin(input int idx, input logic lvl);
		@(posedge clk);
		pin_req[idx] <= lvl;
		repeat (8) @(posedge clk);
	endtask

	// Stopping the run bit zeroes the counter whatever the clear bit and compare values
	task automatic restart;
		@(posedge clk);
		run <= 1'b0;
		repeat (2) @(posedge clk);
		run <= 1'b1;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset;
		logic [7:0] d;
		rd(TCC_ADDR_MODE, d);
		chk("mode reset", {8'h00, d}, 16'h00e0);
		rd(TCC_ADDR_TOGGLE, d);
		chk("toggle reset", {8'h00, d}, 16'h00c3);
		rd(16'hffd0, d);
		chk("unmapped", {8'h00, d}, 16'h0000);
		rd(TCC_ADDR_CMP1_LO, d);
		chk("compare read", {8'h00, d}, 16'h0000);
		chk("outs reset", {12'h000, m1, m2, xa, tff}, 16'h0000);
	endtask

	// Each source gets a different number of edges so a wrong select shows
	task automatic t_clock_sel;
		logic [15:0] v;
		logic [15:0] exp [4] = '{16'h0001, 16'h0002, 16'h0003, 16'h0000};
		for (int c = 0; c < 4; c++) begin
			restart();
			mode(2'h0, 1'b0, c[1:0], 1'b1);
			pin(0, 1'b1);
			pin(0, 1'b0);
			tick(1'b0, 2);
			tick(1'b1, 3);
			mode(2'h0, 1'b0, c[1:0], 1'b0);
			rd16(TCC_ADDR_CAPTURE_FIRST_VALUE_LO, v);
			chk("clock select count", v, exp[c]);
		end
		mode(2'h0, 1'b0, 2'h1, 1'b1);
		tick(1'b0, 3);
		@(posedge clk);
		run <= 1'b0;
		tick(1'b0, 2);
		mode(2'h0, 1'b0, 2'h1, 1'b0);
		rd16(TCC_ADDR_CAPTURE_FIRST_VALUE_LO, v);
		chk("stopped count", v, 16'h0000);
	endtask

	task automatic t_compare(input logic cle, input int e1, input int e2, input int ef,
		input logic [15:0] ecap);
		int b1, b2, bf;
		logic [15:0] v;
		restart();
		wr16(TCC_ADDR_CMP1_LO, 16'h0002);
		wr16(TCC_ADDR_CMP2_LO, 16'h0004);
		wr(TCC_ADDR_TOGGLE, 8'h0c);
		mode(2'h0, cle, 2'h1, 1'b1);
		b1 = n_m1;
		b2 = n_m2;
		bf = n_flip;
		tick(1'b0, 10);
		repeat (6) @(posedge clk);
		chk("first irqs", 16'(n_m1 - b1), 16'(e1));
		chk("second irqs", 16'(n_m2 - b2), 16'(e2));
		chk("match flips", 16'(n_flip - bf), 16'(ef));
		mode(2'h0, cle, 2'h1, 1'b0);
		rd16(TCC_ADDR_CAPTURE_FIRST_VALUE_LO, v);
		chk("count after", v, ecap);
	endtask

	task automatic t_capture;
		int bx, bf;
		logic [15:0] v;
		int ex [4] = '{1, 1, 1, 0};
		for (int m = 0; m < 4; m++) begin
			restart();
			wr(TCC_ADDR_TOGGLE, 8'h30);
			mode(m[1:0], 1'b0, 2'h1, 1'b1);
			bx = n_xa;
			bf = n_flip;
			tick(1'b0, 3);
			pin((m == 3) ? 2 : 0, 1'b1);
			tick(1'b0, 2);
			pin((m == 1) ? 1 : ((m == 3) ? 2 : 0), (m == 1));
			rd16(TCC_ADDR_CAPTURE_FIRST_VALUE_LO, v);
			chk("first capture", v, (m == 0) ? 16'h0000 : 16'h0003);
			rd16(TCC_ADDR_CAPTURE_SECOND_VALUE_LO, v);
			chk("second capture", v, (m == 0) ? 16'h0000 : 16'h0005);
			chk("pin a irqs", 16'(n_xa - bx), 16'(ex[m]));
			chk("capture flips", 16'(n_flip - bf), (m == 0) ? 16'h0000 : 16'h0002);
			pin(0, 1'b0);
			pin(1, 1'b0);
		end
	endtask

	task automatic t_sw_toggle;
		logic [1:0] act [5] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
		logic expv [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
		for (int i = 0; i < 5; i++) begin
			wr(TCC_ADDR_TOGGLE, {6'h00, act[i]});
			repeat (2) @(posedge clk);
			chk("soft toggle", {15'h0000, tff}, {15'h0000, expv[i]});
			chk("pin level", {15'h0000, tpin}, {15'h0000, expv[i]});
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			p8 <= i[0] ? 8'h08 : 8'h00;
			smm <= i[1] ? 8'h30 : 8'h20;
			repeat (3) @(posedge clk);
			chk("pin enable", {15'h0000, toe}, (i == 3) ? 16'h0001 : 16'h0000);
		end
	endtask

	// ************************************************************
	// Sequence and verdict
	// ************************************************************
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Whole sequence needs under ten thousand cycles; the limit leaves wide margin
	initial begin
		#400000;
		num_errors++;
		summarize();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_capture();
		t_clock_sel();
		t_compare(1'b1, 2, 2, 4, 16'h0000);
		t_compare(1'b0, 1, 1, 2, 16'h000a);
		t_sw_toggle();
		summarize();
	end
endmodule
